// file: verilog/rtm_timer_core.sv
// Purpose: one reloadable 32-bit timer with its four registers
// Assumes: request is one-cycle, decoded for this instance; rx already synchronised
// Notes: undefined divider codes behave as the largest division
`timescale 1ns/1ps
`default_nettype none
module rtm_timer_core (
    // clock and reset
    input wire logic clk_i,
    input wire logic sys_rst_i,
    // register access
    input wire rtm_pkg::rtm_bus_req_s req_i,
    output logic [31:0] rdata_o,
    // ring and lines
    input wire logic cascade_i,
    input wire logic rx_i,
    output logic timeout_o,
    output logic irq_o
);
    import rtm_pkg::*;

    logic [31:0] count_ff;
    logic [31:0] compare_ff;
    logic [31:0] control_ff;
    logic irq_pend_ff;
    logic [11:0] presc_ff;
    logic rx_prev_ff;
    rtm_ab_e ab_state_ff;
    logic [2:0] ab_edges_ff;
    logic wr_stb;
    logic count_go;
    logic [2:0] operating_select;
    logic [3:0] clock_divider_sel;
    logic tick;
    logic hit;
    logic rx_rise;
    logic rx_fall;
    logic ab_done;
    logic ab_ovf;

    assign wr_stb = req_i.sel & req_i.enable & req_i.write;
    assign count_go = control_ff[RTM_COUNT_GO_BIT];
    assign operating_select = control_ff[RTM_MODE_MSB:0];
    assign clock_divider_sel = rtm_div_sel(control_ff);
    assign rx_rise = rx_i & ~rx_prev_ff;
    assign rx_fall = ~rx_i & rx_prev_ff;

    ////////////////////////////////////////////////////////////////////////
    // prescaler: tick when the low bits selected all reach ones
    always_comb begin
        logic [3:0] sel;
        logic [11:0] mask;
        sel = (clock_divider_sel > RTM_DIV_MAX) ? RTM_DIV_MAX : clock_divider_sel;
        mask = 12'(({13'h0001} << sel) - 13'h0001);
        if (operating_select == RTM_MODE_CASCADE) begin
            tick = cascade_i;
        end else begin
            tick = ((presc_ff & mask) == mask);
        end
    end

    always_ff @(posedge clk_i) begin
        if (sys_rst_i || !count_go || operating_select == RTM_MODE_CASCADE) begin
            presc_ff <= 12'h000;
        end else begin
            presc_ff <= presc_ff + 12'h001;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // terminal event and auto-baud measurement
    assign hit = count_go && tick && (count_ff == compare_ff) && (operating_select != RTM_MODE_AUTOBAUD);
    assign ab_ovf = (ab_state_ff == RTM_AB_MEASURE || ab_state_ff == RTM_AB_IN_START) && tick
                    && (count_ff == compare_ff);
    assign ab_done = (ab_state_ff == RTM_AB_MEASURE) && rx_rise && (ab_edges_ff == 3'(RTM_AUTOBAUD_EDGES - 1));

    always_ff @(posedge clk_i) begin
        rx_prev_ff <= sys_rst_i ? 1'b1 : rx_i;
    end

    always_ff @(posedge clk_i) begin
        if (sys_rst_i || !count_go || operating_select != RTM_MODE_AUTOBAUD) begin
            ab_state_ff <= RTM_AB_WAIT_IDLE;
            ab_edges_ff <= 3'h0;
        end else begin
            case (ab_state_ff)
                RTM_AB_WAIT_IDLE: begin
                    if (rx_i) begin
                        ab_state_ff <= RTM_AB_WAIT_START;
                    end
                end
                RTM_AB_WAIT_START: begin
                    if (rx_fall) begin
                        ab_state_ff <= RTM_AB_IN_START;
                    end
                end
                RTM_AB_IN_START: begin
                    if (ab_ovf) begin
                        ab_state_ff <= RTM_AB_WAIT_IDLE;
                    end else if (rx_rise) begin
                        ab_state_ff <= RTM_AB_MEASURE;
                        ab_edges_ff <= 3'h0;
                    end
                end
                RTM_AB_MEASURE: begin
                    if (ab_ovf) begin
                        ab_state_ff <= RTM_AB_WAIT_IDLE;
                    end else if (rx_rise) begin
                        ab_edges_ff <= ab_edges_ff + 3'h1;
                    end
                end
                default: begin
                    ab_state_ff <= RTM_AB_WAIT_IDLE;
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // count register
    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            count_ff <= RTM_RST_COUNT;
        end else if (wr_stb && req_i.offset == RTM_OFF_COUNT) begin
            count_ff <= req_i.wdata;
        end else if (operating_select == RTM_MODE_AUTOBAUD) begin
            if (!count_go || ab_ovf || (ab_state_ff == RTM_AB_IN_START && rx_rise)) begin
                count_ff <= count_go ? RTM_RELOAD_VALUE : count_ff;
            end else if ((ab_state_ff == RTM_AB_IN_START || ab_state_ff == RTM_AB_MEASURE) && tick && !ab_done) begin
                count_ff <= count_ff + 32'h00000001;
            end
        end else if (hit) begin
            count_ff <= RTM_RELOAD_VALUE;
        end else if (count_go && tick) begin
            count_ff <= count_ff + 32'h00000001;
        end
    end

    // compare register
    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            compare_ff <= RTM_RST_COMPARE;
        end else if (wr_stb && req_i.offset == RTM_OFF_COMPARE) begin
            compare_ff <= req_i.wdata;
        end
    end

    // control register; hardware clears the go bit after one-shot or a measurement
    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            control_ff <= RTM_RST_CONTROL;
        end else if (wr_stb && req_i.offset == RTM_OFF_CONTROL) begin
            control_ff <= req_i.wdata & RTM_CONTROL_MASK;
        end else if ((hit && operating_select == RTM_MODE_ONE_SHOT) || ab_done) begin
            control_ff[RTM_COUNT_GO_BIT] <= 1'b0;
        end
    end

    // pending flag: a new event wins over a same-cycle clear
    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            irq_pend_ff <= 1'b0;
        end else if (hit || ab_done) begin
            irq_pend_ff <= 1'b1;
        end else if (wr_stb && req_i.offset == RTM_OFF_IRQ_ACK && req_i.wdata[RTM_IRQ_ACK_BIT]) begin
            irq_pend_ff <= 1'b0;
        end
    end

    always_ff @(posedge clk_i) begin
        timeout_o <= sys_rst_i ? 1'b0 : hit;
    end

    assign irq_o = irq_pend_ff;

    // read mux
    always_comb begin
        case (req_i.offset)
            RTM_OFF_COUNT: rdata_o = count_ff;
            RTM_OFF_COMPARE: rdata_o = compare_ff;
            RTM_OFF_IRQ_ACK: rdata_o = {31'h00000000, irq_pend_ff};
            RTM_OFF_CONTROL: rdata_o = control_ff & RTM_CONTROL_MASK;
            default: rdata_o = 32'h00000000;
        endcase
    end
endmodule
`default_nettype wire

// file: shared/rtm_pkg.sv
// Purpose: constants and carriers for the five-instance reloadable 32-bit timer block
// Assumes: registers reached over a simple APB-style slave port, one word per register
// Notes: per-instance base addresses are decoded in the top module
package rtm_pkg;
    localparam int RTM_NUM_TIMERS = 5;
    localparam logic [31:0] RTM_BASE_FIRST = 32'hFFFE7000;
    localparam logic [31:0] RTM_BASE_LAST = 32'hFFFEB000;
    localparam logic [31:0] RTM_BASE_STRIDE = 32'h00001000;
    localparam logic [11:0] RTM_OFF_COUNT = 12'h000;
    localparam logic [11:0] RTM_OFF_COMPARE = 12'h004;
    localparam logic [11:0] RTM_OFF_IRQ_ACK = 12'h00C;
    localparam logic [11:0] RTM_OFF_CONTROL = 12'h010;
    localparam logic [31:0] RTM_RST_COUNT = 32'h00000000;
    localparam logic [31:0] RTM_RST_COMPARE = 32'hFFFFFFFF;
    localparam logic [31:0] RTM_RST_CONTROL = 32'h00000000;
    localparam logic [31:0] RTM_RELOAD_VALUE = 32'h00000001;
    localparam int RTM_IRQ_ACK_BIT = 0;
    localparam int RTM_COUNT_GO_BIT = 7;
    localparam int RTM_DIV_HI_BIT = 8;
    localparam int RTM_DIV_LO_MSB = 5;
    localparam int RTM_DIV_LO_LSB = 3;
    localparam int RTM_MODE_MSB = 2;
    localparam logic [3:0] RTM_DIV_MAX = 4'hC;
    localparam logic [31:0] RTM_CONTROL_MASK = 32'h000001BF;
    localparam int RTM_AUTOBAUD_EDGES = 2;

    typedef enum logic [2:0] {
        RTM_MODE_ONE_SHOT = 3'b000,
        RTM_MODE_CONTINUOUS = 3'b001,
        RTM_MODE_CASCADE = 3'b010,
        RTM_MODE_COMPARE = 3'b101,
        RTM_MODE_AUTOBAUD = 3'b111
    } rtm_mode_e;

    typedef enum logic [1:0] {
        RTM_AB_WAIT_IDLE = 2'b00,
        RTM_AB_WAIT_START = 2'b01,
        RTM_AB_IN_START = 2'b10,
        RTM_AB_MEASURE = 2'b11
    } rtm_ab_e;

    typedef struct packed {
        logic sel;
        logic enable;
        logic write;
        logic [11:0] offset;
        logic [31:0] wdata;
    } rtm_bus_req_s;

    function automatic logic [3:0] rtm_div_sel(input logic [31:0] ctl);
        return {ctl[RTM_DIV_HI_BIT], ctl[RTM_DIV_LO_MSB:RTM_DIV_LO_LSB]};
    endfunction
endpackage

// file: verilog/rtm_timer_block.sv
// Function
// - five timers, each decoded at its own fixed base, same layout
// - count register holds live 32-bit value, read/write, resets zero
// - count write while running loads next edge; counting continues from it
// - compare resets to all ones; reaching it reloads count to one
// - writing one to irq ack bit 0 clears pending; upper bits zero
// - control bit 7 lets counter advance; reserved control bits read zero
// - four-bit divider field divides clock by two to its power; codes above 12 divide by 4096
// - three-bit mode field selects one-shot, continuous, cascade, compare, auto-baud
// - one-shot terminal: interrupt, count to one, enable cleared
// - continuous and compare terminal: interrupt, count to one, keep counting
// - cascade mode counts preceding timer time-outs in a ring, no prescale
// - auto-baud measures eight bit-times on rx, clears enable on success
//
// Purpose: five reloadable timers behind one APB-style register port
// Assumes: rx lines are asynchronous pins; bus signals are on clk_i
// Notes: read data and interrupts are registered; read data is captured in setup, so reads answer in the access cycle
`timescale 1ns/1ps
`default_nettype none
module rtm_timer_block #(
    parameter int NUM_TIMERS = rtm_pkg::RTM_NUM_TIMERS
) (
    // clock and reset
    input wire logic clk_i,
    input wire logic sys_rst_i,
    // apb slave
    input wire logic psel_i,
    input wire logic penable_i,
    input wire logic pwrite_i,
    input wire logic [31:0] paddr_i,
    input wire logic [31:0] pwdata_i,
    output logic [31:0] prdata_o,
    output logic pready_o,
    output logic pslverr_o,
    // serial receive lines for auto-baud
    input wire logic [NUM_TIMERS-1:0] rx_i,
    // interrupts
    output logic [NUM_TIMERS-1:0] irq_o
);
    import rtm_pkg::*;

    logic [NUM_TIMERS-1:0] rx_meta_ff;
    logic [NUM_TIMERS-1:0] rx_sync_ff;
    logic [NUM_TIMERS-1:0] timeout;
    logic [NUM_TIMERS-1:0] irq_raw;
    logic [31:0] rdata [NUM_TIMERS];
    logic [NUM_TIMERS-1:0] hit_sel;
    logic [31:0] rd_mux;
    logic any_hit;

    ////////////////////////////////////////////////////////////////////////
    // synchronise rx pins before any logic sees them
    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            rx_meta_ff <= '1;
            rx_sync_ff <= '1;
        end else begin
            rx_meta_ff <= rx_i;
            rx_sync_ff <= rx_meta_ff;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // instances on their bases, cascade ring closes last to first
    for (genvar g = 0; g < NUM_TIMERS; g++) begin : g_tmr
        rtm_bus_req_s req;
        assign hit_sel[g] = (paddr_i[31:12] == 20'((RTM_BASE_FIRST + RTM_BASE_STRIDE * 32'(g)) >> 12));
        assign req.sel = psel_i & hit_sel[g];
        assign req.enable = penable_i;
        assign req.write = pwrite_i;
        assign req.offset = paddr_i[11:0];
        assign req.wdata = pwdata_i;
        rtm_timer_core u_core (
            .clk_i(clk_i),
            .sys_rst_i(sys_rst_i),
            .req_i(req),
            .rdata_o(rdata[g]),
            .cascade_i(timeout[(g + NUM_TIMERS - 1) % NUM_TIMERS]),
            .rx_i(rx_sync_ff[g]),
            .timeout_o(timeout[g]),
            .irq_o(irq_raw[g])
        );
    end

    always_comb begin
        rd_mux = 32'h00000000;
        any_hit = 1'b0;
        for (int i = 0; i < NUM_TIMERS; i++) begin
            if (hit_sel[i]) begin
                rd_mux = rdata[i];
                any_hit = 1'b1;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // bus answer: setup then access; access phase holds ready high
    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            prdata_o <= 32'h00000000;
            pready_o <= 1'b0;
            pslverr_o <= 1'b0;
        end else begin
            pready_o <= psel_i & ~penable_i;
            pslverr_o <= psel_i & ~penable_i & ~any_hit;
            prdata_o <= (psel_i & ~penable_i & ~pwrite_i) ? rd_mux : 32'h00000000;
        end
    end

    always_ff @(posedge clk_i) begin
        irq_o <= sys_rst_i ? '0 : irq_raw;
    end
endmodule
`default_nettype wire

// file: dv/rtm_timer_block_assertions.sv
// Purpose: port-level checks of the five-timer block
// Assumes: bus on clk_i, synchronous active-high reset
// Notes: interrupt hold is watched on timer 0 only
`timescale 1ns/1ps
`default_nettype none
module rtm_timer_block_assertions #(
    parameter int NUM_TIMERS = 5
) (
    // clock and reset
    input wire logic clk_i,
    input wire logic sys_rst_i,
    // bus
    input wire logic psel_i,
    input wire logic penable_i,
    input wire logic pwrite_i,
    input wire logic [31:0] paddr_i,
    input wire logic [31:0] pwdata_i,
    input wire logic [31:0] prdata_o,
    input wire logic pready_o,
    input wire logic pslverr_o,
    // lines
    input wire logic [NUM_TIMERS-1:0] rx_i,
    input wire logic [NUM_TIMERS-1:0] irq_o
);
    import rtm_pkg::*;
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (sys_rst_i);
    logic acc, rd, in_rng, ack0;
    assign acc = psel_i && penable_i;
    assign in_rng = paddr_i >= RTM_BASE_FIRST && paddr_i < RTM_BASE_LAST + RTM_BASE_STRIDE;
    assign rd = acc && !pwrite_i && in_rng;
    assign ack0 = acc && pwrite_i && paddr_i == RTM_BASE_FIRST + {20'h0, RTM_OFF_IRQ_ACK} && pwdata_i[0];
    ////////////////////////////////////////////////////////////////
    a_bus_answer: assert property (acc |-> pready_o && (pslverr_o == !in_rng))
        else $error("access answered with wrong ready or error");
    a_ready_pulse: assert property (pready_o |-> acc ##1 !pready_o)
        else $error("ready outside a single access cycle");
    a_idle_quiet: assert property (!psel_i |=> !pready_o && !pslverr_o)
        else $error("answer without a select");
    a_gap_zero: assert property (rd && paddr_i[11:0] == 12'h008 |-> prdata_o == 32'h0)
        else $error("unmapped offset read nonzero");
    a_ctl_reserved: assert property (rd && paddr_i[11:0] == RTM_OFF_CONTROL
        |-> (prdata_o & ~RTM_CONTROL_MASK) == 32'h0)
        else $error("reserved control bits read nonzero");
    a_ack_reserved: assert property (rd && paddr_i[11:0] == RTM_OFF_IRQ_ACK |-> prdata_o[31:1] == 31'h0)
        else $error("upper ack bits read nonzero");
    a_irq_hold: assert property (irq_o[0] && !ack0 && !$past(ack0) |=> irq_o[0])
        else $error("interrupt dropped without a clear");
    a_rst_quiet: assert property ($fell(sys_rst_i) |-> !pready_o && irq_o == '0)
        else $error("outputs not quiet after reset");
    c_write: cover property (acc && pwrite_i && in_rng);
    c_irq: cover property ($rose(irq_o[0]));
    c_outside: cover property (acc && !in_rng);
endmodule
`default_nettype wire

// file: dv/rtm_apb_master.sv
// Purpose: bus master and serial line driver facing the timer block
// Assumes: zero-wait slave, ready sampled at rising edge
// Notes: released bus shows inverted values so stale data cannot pass
`timescale 1ns/1ps
`default_nettype none
module rtm_apb_master (
    // clock
    input wire logic clk_i,
    // bus
    output logic psel_o,
    output logic penable_o,
    output logic pwrite_o,
    output logic [31:0] paddr_o,
    output logic [31:0] pwdata_o,
    input wire logic [31:0] prdata_i,
    input wire logic pready_i,
    input wire logic pslverr_i,
    // serial lines, idle high
    output logic [4:0] rx_o
);
    initial begin
        psel_o = 1'b0;
        penable_o = 1'b0;
        pwrite_o = 1'b0;
        paddr_o = 32'h0;
        pwdata_o = 32'h0;
        rx_o = 5'h1F;
    end
    task automatic xfer(input logic wr, input logic [31:0] a, input logic [31:0] d,
                        output logic [31:0] q, output logic e);
        int n;
        n = 0;
        @(negedge clk_i);
        psel_o = 1'b1;
        penable_o = 1'b0;
        pwrite_o = wr;
        paddr_o = a;
        pwdata_o = d;
        @(negedge clk_i);
        penable_o = 1'b1;
        @(posedge clk_i);
        while (pready_i !== 1'b1 && n < 16) begin
            @(posedge clk_i);
            n++;
        end
        // stuck slave hands back unknowns so the caller's compare trips
        q = (n < 16) ? prdata_i : 32'hXXXXXXXX;
        e = (n < 16) ? pslverr_i : 1'bX;
        @(negedge clk_i);
        psel_o = 1'b0;
        penable_o = 1'b0;
        paddr_o = ~a;
        pwdata_o = ~d;
    endtask
    // frame lsb first: start, eight data, stop
    task automatic send_char(input int idx, input int bc, input logic [7:0] ch);
        logic [9:0] f;
        f = {1'b1, ch, 1'b0};
        for (int i = 0; i < 10; i++) begin
            @(negedge clk_i);
            rx_o[idx] = f[i];
            repeat (bc - 1) @(negedge clk_i);
        end
    endtask
endmodule
`default_nettype wire

// file: dv/rtm_timer_block_tb_top.sv
// Purpose: self-checking bench for the five-timer block
// Assumes: reads answered in the access cycle
// Notes: count checks allow a few cycles of bus latency
`timescale 1ns/1ps
`default_nettype none
module rtm_timer_block_tb_top;
    import rtm_pkg::*;
    localparam logic [2:0] MODES [5] = '{3'b000, 3'b001, 3'b010, 3'b101, 3'b111};
    logic clk_i = 1'b0;
    logic sys_rst_i = 1'b1;
    logic psel_i, penable_i, pwrite_i, pready_o, pslverr_o, e;
    logic [31:0] paddr_i, pwdata_i, prdata_o, q;
    logic [4:0] rx_i, irq_o;
    int errors = 0;
    int checked = 0;
    int cyc = 0;
    initial forever #2.5 clk_i = ~clk_i;
    rtm_timer_block dut_u (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .psel_i(psel_i), .penable_i(penable_i),
        .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i), .prdata_o(prdata_o),
        .pready_o(pready_o), .pslverr_o(pslverr_o), .rx_i(rx_i), .irq_o(irq_o));
    rtm_apb_master bfm_u (.clk_i(clk_i), .psel_o(psel_i), .penable_o(penable_i), .pwrite_o(pwrite_i),
        .paddr_o(paddr_i), .pwdata_o(pwdata_i), .prdata_i(prdata_o), .pready_i(pready_o),
        .pslverr_i(pslverr_o), .rx_o(rx_i));
    ////////////////////////////////////////////////////////////////
    task automatic test_done();
        $display("checked %0d errors %0d", checked, errors);
        if (errors == 0 && checked > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask
    always @(posedge clk_i) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            errors = errors + 1;
            $display("MISMATCH run time expected finish seen hang");
            test_done();
        end
    end
    task automatic chk(input string n, input logic [31:0] x, input logic [31:0] g);
        checked++;
        if (g !== x) begin
            errors++;
            $display("MISMATCH %s expected %h seen %h", n, x, g);
        end
    endtask
    task automatic chk_rng(input string n, input logic [31:0] lo, input logic [31:0] hi, input logic [31:0] g);
        checked++;
        if (((g >= lo) && (g <= hi)) !== 1'b1) begin
            errors++;
            $display("MISMATCH %s expected %h to %h seen %h", n, lo, hi, g);
        end
    endtask
    function automatic logic [31:0] adr(input int t, input logic [11:0] o);
        return RTM_BASE_FIRST + RTM_BASE_STRIDE * 32'(t) + {20'h0, o};
    endfunction
    function automatic logic [31:0] ctl(input logic go, input logic [3:0] dv, input logic [2:0] m);
        return {23'h0, dv[3], go, 1'b0, dv[2:0], m};
    endfunction
    task automatic wr(input int t, input logic [11:0] o, input logic [31:0] d);
        bfm_u.xfer(1'b1, adr(t, o), d, q, e);
    endtask
    task automatic rd(input int t, input logic [11:0] o);
        bfm_u.xfer(1'b0, adr(t, o), 32'h0, q, e);
    endtask
    ////////////////////////////////////////////////////////////////
    initial begin
        int bc;
        logic [31:0] d;
        logic [3:0] dv;
        void'($urandom(32'hA0F07576));
        repeat (20) @(posedge clk_i);
        @(negedge clk_i);
        sys_rst_i = 1'b0;
        for (int t = 0; t < 5; t++) begin
            rd(t, RTM_OFF_COUNT);
            chk("count reset", RTM_RST_COUNT, q);
            rd(t, RTM_OFF_COMPARE);
            chk("compare reset", RTM_RST_COMPARE, q);
            rd(t, RTM_OFF_CONTROL);
            chk("control reset", RTM_RST_CONTROL, q);
            rd(t, 12'h008);
            chk("gap read", 32'h0, q);
            d = $urandom;
            wr(t, RTM_OFF_COUNT, d);
            rd(t, RTM_OFF_COUNT);
            chk("count rw", d, q);
            wr(t, RTM_OFF_COMPARE, ~d);
            rd(t, RTM_OFF_COMPARE);
            chk("compare rw", ~d, q);
            for (int m = 0; m < 5; m++) begin
                d = ($urandom & 32'hFFFFFF78) | {29'h0, MODES[m]};
                wr(t, RTM_OFF_CONTROL, d);
                rd(t, RTM_OFF_CONTROL);
                chk("control rw", d & RTM_CONTROL_MASK, q);
            end
            wr(t, RTM_OFF_CONTROL, 32'h0);
        end
        bfm_u.xfer(1'b0, RTM_BASE_LAST + RTM_BASE_STRIDE, 32'h0, q, e);
        chk("outside error", 32'h1, {31'h0, e});
        $display("test registers done, errors %0d", errors);
        wr(0, RTM_OFF_COUNT, 32'h0);
        wr(0, RTM_OFF_COMPARE, 32'h5);
        wr(0, RTM_OFF_CONTROL, ctl(1'b1, 4'h0, 3'b000));
        repeat (20) @(negedge clk_i);
        rd(0, RTM_OFF_CONTROL);
        chk("one-shot stop", ctl(1'b0, 4'h0, 3'b000), q);
        rd(0, RTM_OFF_COUNT);
        chk("one-shot count", RTM_RELOAD_VALUE, q);
        chk("one-shot irq", 32'h1, {31'h0, irq_o[0]});
        wr(0, RTM_OFF_IRQ_ACK, 32'hFFFFFFFF);
        repeat (2) @(negedge clk_i);
        chk("irq cleared", 32'h0, {31'h0, irq_o[0]});
        rd(0, RTM_OFF_IRQ_ACK);
        chk("ack upper", 32'h0, q & 32'hFFFFFFFE);
        for (int k = 0; k < 2; k++) begin
            d = ctl(1'b1, 4'h0, (k == 0) ? 3'b001 : 3'b101);
            wr(1, RTM_OFF_CONTROL, 32'h0);
            wr(1, RTM_OFF_IRQ_ACK, 32'h1);
            wr(1, RTM_OFF_COUNT, 32'h0);
            wr(1, RTM_OFF_COMPARE, 32'h3);
            wr(1, RTM_OFF_CONTROL, d);
            repeat (30) @(negedge clk_i);
            chk("reload irq", 32'h1, {31'h0, irq_o[1]});
            rd(1, RTM_OFF_CONTROL);
            chk("still running", d, q);
            rd(1, RTM_OFF_COUNT);
            chk_rng("reload count", 32'h1, 32'h3, q);
        end
        wr(1, RTM_OFF_CONTROL, 32'h0);
        $display("test terminal done, errors %0d", errors);
        for (int k = 0; k < 2; k++) begin
            dv = (k == 1) ? 4'h8 : 4'($urandom_range(3, 0));
            wr(2, RTM_OFF_CONTROL, 32'h0);
            wr(2, RTM_OFF_COUNT, 32'h0);
            wr(2, RTM_OFF_COMPARE, 32'hFFFFFFFF);
            wr(2, RTM_OFF_CONTROL, ctl(1'b1, dv, 3'b001));
            repeat (400) @(negedge clk_i);
            rd(2, RTM_OFF_COUNT);
            chk_rng("divided count", (32'd400 >> dv) - 32'd1, (32'd404 >> dv) + 32'd1, q);
        end
        wr(2, RTM_OFF_CONTROL, ctl(1'b1, 4'h0, 3'b001));
        wr(2, RTM_OFF_COUNT, 32'h1000);
        rd(2, RTM_OFF_COUNT);
        chk_rng("count write running", 32'h1001, 32'h1006, q);
        wr(2, RTM_OFF_CONTROL, 32'h0);
        wr(4, RTM_OFF_COUNT, 32'h0);
        wr(4, RTM_OFF_COMPARE, 32'hFFFFFFFF);
        wr(4, RTM_OFF_CONTROL, ctl(1'b1, 4'h7, 3'b010));
        wr(3, RTM_OFF_COUNT, 32'h0);
        wr(3, RTM_OFF_COMPARE, 32'h4);
        wr(3, RTM_OFF_CONTROL, ctl(1'b1, 4'h0, 3'b001));
        repeat (400) @(negedge clk_i);
        wr(3, RTM_OFF_CONTROL, 32'h0);
        rd(4, RTM_OFF_COUNT);
        chk_rng("cascade count", 32'd98, 32'd102, q);
        wr(4, RTM_OFF_CONTROL, 32'h0);
        $display("test divider cascade done, errors %0d", errors);
        bc = $urandom_range(23, 16);
        wr(3, RTM_OFF_COUNT, 32'h0);
        wr(3, RTM_OFF_COMPARE, 32'h0000FFFF);
        wr(3, RTM_OFF_CONTROL, ctl(1'b1, 4'h0, 3'b111));
        bfm_u.send_char(3, bc, 8'h0D);
        repeat (4) @(negedge clk_i);
        rd(3, RTM_OFF_CONTROL);
        chk("autobaud done", ctl(1'b0, 4'h0, 3'b111), q);
        rd(3, RTM_OFF_COUNT);
        chk_rng("autobaud width", 32'(8 * bc - 2), 32'(8 * bc + 4), q);
        $display("test autobaud done, errors %0d", errors);
        test_done();
    end
endmodule
bind rtm_timer_block rtm_timer_block_assertions #(.NUM_TIMERS(NUM_TIMERS)) chk_u (.clk_i(clk_i),
    .sys_rst_i(sys_rst_i), .psel_i(psel_i), .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i),
    .pwdata_i(pwdata_i), .prdata_o(prdata_o), .pready_o(pready_o), .pslverr_o(pslverr_o), .rx_i(rx_i),
    .irq_o(irq_o));
`default_nettype wire
